// [bemc_pkg.sv]
// Package of constants and carrier types for the buck enable and mode control block
package bemc_pkg;

    // ------------------------------------------------------------------
    // Timing constants
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS     = 10;      // Reference clock period
    localparam int unsigned INIT_TIME_NS      = 1000;    // Initialization phase length
    localparam int unsigned INIT_CYCLES       = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned START_DELAY_NS    = 500;     // Delay from enable high to ramp
    localparam int unsigned START_DELAY_CYC   = (START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RAMP_TIME_NS      = 2000;    // Soft-start ramp length
    localparam int unsigned RAMP_CYCLES       = (RAMP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SW_DIV            = 8;       // Reference cycles per switching cycle
    localparam int unsigned NONSYNC_CYCLES    = 6;       // Low-side off cycles on load release
    localparam int unsigned CNT_W             = 16;      // Width of the timing counters

    // ------------------------------------------------------------------
    // Field values
    // ------------------------------------------------------------------
    localparam logic STANDALONE_ON   = 1'b1;             // Fault pulldown disabled
    localparam logic FORCED_PWM_ON   = 1'b1;             // Forced pulse width operation

    // ------------------------------------------------------------------
    // Load bands and modulation kinds
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BEMC_LOAD_VLOW = 2'h0,                           // Very low load
        BEMC_LOAD_LOW  = 2'h1,                           // Low load
        BEMC_LOAD_MID  = 2'h2,                           // Medium load
        BEMC_LOAD_HIGH = 2'h3
    } bemc_load_t;

    typedef enum logic [1:0] {
        BEMC_MOD_OFF  = 2'h0,                            // Power stage off
        BEMC_MOD_CCM  = 2'h1,                            // Continuous conduction modulation
        BEMC_MOD_DCM  = 2'h2,                            // Discontinuous conduction modulation
        BEMC_MOD_SKIP = 2'h3                             // Pulse skip operation
    } bemc_mod_t;

    // ------------------------------------------------------------------
    // Converter state machine, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        BEMC_ST_INIT  = 5'h01,                           // Loading defaults, sampling straps
        BEMC_ST_SHUT  = 5'h02,                           // Shutdown, enable low
        BEMC_ST_DELAY = 5'h04,                           // Wait before soft start
        BEMC_ST_RAMP  = 5'h08,                           // Soft-start ramp
        BEMC_ST_RUN   = 5'h10                            // Regulating
    } bemc_state_t;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic hs_on;                                     // High-side switch gate
        logic ls_on;                                     // Low-side switch gate
    } bemc_gate_t;

    typedef struct packed {
        logic first_voltage_strap;                       // Captured strap level
        logic second_voltage_strap;                      // Captured strap level
    } bemc_strap_t;

endpackage : bemc_pkg

// [bemc_sync.sv]
// Three-stage synchroniser with agreement-based change detection
`timescale 1ns/1ps
`default_nettype none

module bemc_sync #(
    parameter logic RESET_VAL = 1'b0                     // Level held during reset
) (
    input  wire logic ref_clk_i,                         // Reference clock
    input  wire logic rst_n_i,                           // Synchronous reset, active low
    input  wire logic clk_en_i,                          // Clock enable
    input  wire logic async_i,                           // Input from outside the domain
    output var  logic level_o                            // Filtered synchronised level
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic s1;                                        // First stage, read only by s2
        logic s2;                                        // Second stage
        logic s3;                                        // Third stage
        logic lvl;                                       // Accepted level
    } bemc_sync_st_t;

    bemc_sync_st_t st_q;                                 // Registered state
    bemc_sync_st_t st_d;                                 // Next state

    // Shift and accept a change once stages two and three agree
    always_comb begin
        st_d = st_q;
        if (clk_en_i) begin
            st_d.s1 = async_i;
            st_d.s2 = st_q.s1;
            st_d.s3 = st_q.s2;
            if (st_q.s2 == st_q.s3) begin
                st_d.lvl = st_q.s3;
            end
        end
    end

    // Register state
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st_q <= '{s1: RESET_VAL, s2: RESET_VAL, s3: RESET_VAL, lvl: RESET_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign level_o = st_q.lvl;

endmodule // bemc_sync

`default_nettype wire

// [bemc_ctrl.sv]
// Enable pin, start-up sequencing and operating mode control of the step-down converter
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Hold enable low until initialization done
// - Pull enable low on any fault
// - Shared line gates switching across stack
// - Standalone bit disables fault pulldown
// - Always pull enable low during initialization
// - Release pulldown when no hold
// - Enable high runs, low stops converter
// - Low enable: switches off, control disabled
// - Serial interface ready after initialization only
// - Forced-PWM bit selects operating mode
// - Forced-PWM uses continuous conduction once running
// - Power-save picks modulation by load
// - PWM switches at constant clock frequency
// - Skipped pulses align to internal clock
// - Load release: low-side off six cycles
// - Ramp allows discontinuous and skip modes
// - Short delay before soft-start ramp
module bemc_ctrl #(
    parameter int unsigned INIT_CYC  = bemc_pkg::INIT_CYCLES,     // Initialization length
    parameter int unsigned DELAY_CYC = bemc_pkg::START_DELAY_CYC, // Start delay length
    parameter int unsigned RAMP_CYC  = bemc_pkg::RAMP_CYCLES,     // Soft-start length
    parameter int unsigned DIV_CYC   = bemc_pkg::SW_DIV           // Switching period
) (
    input  wire logic                  ref_clk_i,        // Reference clock, 100 MHz
    input  wire logic                  rst_n_i,          // Power-on reset, active low
    input  wire logic                  clk_en_i,         // Clock enable, freezes state
    input  wire logic                  enable_pin_i,     // Enable pin level
    output var  logic                  enable_pin_o,     // Enable pin drive level
    output var  logic                  enable_pin_oe_o,  // Enable pin pulldown active
    input  wire logic                  fault_i,          // Thermal or overvoltage fault
    input  wire logic                  standalone_i,     // Standalone configuration bit
    input  wire logic                  forced_pwm_select_i, // Forced-PWM configuration bit
    input  wire logic                  nonsync_en_i,     // Non-synchronous mode option
    input  wire logic                  load_release_i,   // Load release event, pulse
    input  wire bemc_pkg::bemc_load_t  load_band_i,      // Measured load band
    input  wire logic                  skip_req_i,       // Pulse requested in skip mode
    input  wire logic                  first_voltage_strap_i,  // Strap pin level
    input  wire logic                  second_voltage_strap_i, // Strap pin level
    output var  bemc_pkg::bemc_strap_t strap_o,          // Straps captured at init
    output var  logic                  serial_ready_o,   // Serial interface operational
    output var  logic                  converter_on_o,   // Control circuitry enabled
    output var  logic                  ramp_active_o,    // Soft-start ramp in progress
    output var  bemc_pkg::bemc_mod_t   modulation_o,     // Active modulation kind
    output var  bemc_pkg::bemc_gate_t  gate_o,           // Power-stage gate drive
    output var  logic                  forced_pulse_width_operation_o, // Forced mode
    output var  logic                  power_save_operation_o          // Power-save mode
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        bemc_pkg::bemc_state_t st;                       // Sequencer state
        logic [bemc_pkg::CNT_W-1:0] cnt;                 // Sequencer timer
        logic [bemc_pkg::CNT_W-1:0] div;                 // Switching period divider
        logic [2:0] nsc;                                 // Non-synchronous cycles left
        logic hold;                                      // Enable pulldown active
        logic fault;                                     // Registered fault level
        bemc_pkg::bemc_strap_t strap;                    // Captured straps
        bemc_pkg::bemc_mod_t mod;                        // Active modulation
        bemc_pkg::bemc_gate_t gate;                      // Gate drive
    } bemc_st_t;

    bemc_st_t st_q;                                      // Registered state
    bemc_st_t st_d;                                      // Next state
    logic     en_sync;                                   // Synchronised enable level
    logic     tick;                                      // Switching period boundary

    localparam logic [bemc_pkg::CNT_W-1:0] INIT_END  = bemc_pkg::CNT_W'(INIT_CYC - 1);
    localparam logic [bemc_pkg::CNT_W-1:0] DELAY_END = bemc_pkg::CNT_W'(DELAY_CYC - 1);
    localparam logic [bemc_pkg::CNT_W-1:0] RAMP_END  = bemc_pkg::CNT_W'(RAMP_CYC - 1);
    localparam logic [bemc_pkg::CNT_W-1:0] DIV_END   = bemc_pkg::CNT_W'(DIV_CYC - 1);
    localparam logic [2:0] NS_LOAD = 3'(bemc_pkg::NONSYNC_CYCLES);

    // ------------------------------------------------------------------
    // Enable pin synchroniser
    // ------------------------------------------------------------------
    // Pin level passes three stages before steering the sequencer
    bemc_sync #(
        .RESET_VAL (1'b0)
    ) u_en_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .clk_en_i  (clk_en_i),
        .async_i   (enable_pin_i),
        .level_o   (en_sync)
    );

    assign tick = (st_q.div == DIV_END);

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        if (clk_en_i) begin
            st_d.fault = fault_i;
            // Free-running switching clock divider
            st_d.div = tick ? '0 : st_q.div + 1'b1;
            // Pulldown: always in init, on fault unless standalone
            st_d.hold = (st_q.st == bemc_pkg::BEMC_ST_INIT)
                      | (st_q.fault & (standalone_i != bemc_pkg::STANDALONE_ON));
            // Sequencer
            case (st_q.st)
                bemc_pkg::BEMC_ST_INIT: begin
                    // Sample straps while defaults load
                    st_d.strap = '{first_voltage_strap: first_voltage_strap_i,
                                   second_voltage_strap: second_voltage_strap_i};
                    st_d.cnt = st_q.cnt + 1'b1;
                    if (st_q.cnt == INIT_END) begin
                        st_d.st  = bemc_pkg::BEMC_ST_SHUT;
                        st_d.cnt = '0;
                    end
                end
                bemc_pkg::BEMC_ST_SHUT: begin
                    st_d.cnt = '0;
                    if (en_sync) begin
                        st_d.st = bemc_pkg::BEMC_ST_DELAY;
                    end
                end
                bemc_pkg::BEMC_ST_DELAY: begin
                    st_d.cnt = st_q.cnt + 1'b1;
                    if (st_q.cnt == DELAY_END) begin
                        st_d.st  = bemc_pkg::BEMC_ST_RAMP;
                        st_d.cnt = '0;
                    end
                end
                bemc_pkg::BEMC_ST_RAMP: begin
                    st_d.cnt = st_q.cnt + 1'b1;
                    if (st_q.cnt == RAMP_END) begin
                        st_d.st  = bemc_pkg::BEMC_ST_RUN;
                        st_d.cnt = '0;
                    end
                end
                bemc_pkg::BEMC_ST_RUN: begin
                    st_d.cnt = '0;
                end
                default: begin
                    st_d.st  = bemc_pkg::BEMC_ST_INIT;
                    st_d.cnt = '0;
                end
            endcase
            // Low enable level shuts the converter down from any active state
            if (st_q.st != bemc_pkg::BEMC_ST_INIT && !en_sync) begin
                st_d.st  = bemc_pkg::BEMC_ST_SHUT;
                st_d.cnt = '0;
            end
            // Modulation selection
            if (st_d.st == bemc_pkg::BEMC_ST_RAMP
                || st_d.st == bemc_pkg::BEMC_ST_RUN) begin
                if (st_d.st == bemc_pkg::BEMC_ST_RAMP
                    || forced_pwm_select_i != bemc_pkg::FORCED_PWM_ON) begin
                    case (load_band_i)
                        bemc_pkg::BEMC_LOAD_VLOW: st_d.mod = bemc_pkg::BEMC_MOD_SKIP;
                        bemc_pkg::BEMC_LOAD_LOW:  st_d.mod = bemc_pkg::BEMC_MOD_DCM;
                        default:                  st_d.mod = bemc_pkg::BEMC_MOD_CCM;
                    endcase
                end else begin
                    st_d.mod = bemc_pkg::BEMC_MOD_CCM;
                end
            end else begin
                st_d.mod = bemc_pkg::BEMC_MOD_OFF;
            end
            // Non-synchronous window counts switching cycles
            if (st_d.mod == bemc_pkg::BEMC_MOD_OFF) begin
                st_d.nsc = '0;
            end else if (load_release_i && nonsync_en_i) begin
                st_d.nsc = NS_LOAD;
            end else if (tick && st_q.nsc != '0) begin
                st_d.nsc = st_q.nsc - 1'b1;
            end
            // Gate drive, pulses start on switching clock boundaries
            case (st_d.mod)
                bemc_pkg::BEMC_MOD_CCM,
                bemc_pkg::BEMC_MOD_DCM: begin
                    st_d.gate.hs_on = (st_d.div < (DIV_END >> 1));
                    st_d.gate.ls_on = !st_d.gate.hs_on && (st_d.nsc == '0)
                                    && (st_d.mod == bemc_pkg::BEMC_MOD_CCM);
                end
                bemc_pkg::BEMC_MOD_SKIP: begin
                    // A requested pulse only begins at a clock boundary
                    if (tick) begin
                        st_d.gate.hs_on = skip_req_i;
                    end else if (st_d.div == (DIV_END >> 1)) begin
                        st_d.gate.hs_on = 1'b0;
                    end
                    st_d.gate.ls_on = 1'b0;
                end
                default: begin
                    st_d.gate = '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st_q <= '{st: bemc_pkg::BEMC_ST_INIT, cnt: '0, div: '0, nsc: '0,
                      hold: 1'b1, fault: 1'b0, strap: '0,
                      mod: bemc_pkg::BEMC_MOD_OFF, gate: '0};
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign enable_pin_o    = 1'b0;                       // Open drain drives low only
    assign enable_pin_oe_o = st_q.hold;
    assign strap_o         = st_q.strap;
    assign serial_ready_o  = (st_q.st != bemc_pkg::BEMC_ST_INIT);
    assign converter_on_o  = (st_q.st == bemc_pkg::BEMC_ST_RAMP)
                           | (st_q.st == bemc_pkg::BEMC_ST_RUN);
    assign ramp_active_o   = (st_q.st == bemc_pkg::BEMC_ST_RAMP);
    assign modulation_o    = st_q.mod;
    assign gate_o          = st_q.gate;
    assign forced_pulse_width_operation_o = (forced_pwm_select_i == bemc_pkg::FORCED_PWM_ON);
    assign power_save_operation_o = !forced_pulse_width_operation_o;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_init_hold;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (st_q.st == bemc_pkg::BEMC_ST_INIT) |-> enable_pin_oe_o;
    endproperty
    a_init_hold: assert property (p_init_hold) else $error("pulldown off during init");

    property p_fault_pull;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (clk_en_i && st_q.fault && !standalone_i) |=> enable_pin_oe_o;
    endproperty
    a_fault_pull: assert property (p_fault_pull) else $error("fault did not pull enable");

    property p_standalone;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (clk_en_i && standalone_i && st_q.st != bemc_pkg::BEMC_ST_INIT) |=> !enable_pin_oe_o;
    endproperty
    a_standalone: assert property (p_standalone) else $error("standalone pulldown active");

    property p_serial;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        serial_ready_o |=> serial_ready_o;
    endproperty
    a_serial: assert property (p_serial) else $error("serial interface lost");

    property p_shutdown;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !converter_on_o |-> (gate_o == '0);
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("gates on in shutdown");

    property p_forced_pulse_width_operation;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (clk_en_i && forced_pwm_select_i && st_d.st == bemc_pkg::BEMC_ST_RUN)
        |=> (modulation_o == bemc_pkg::BEMC_MOD_CCM);
    endproperty
    a_forced_pulse_width_operation: assert property (p_forced_pulse_width_operation) else $error("forced mode not continuous");

    property p_nonsync;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (clk_en_i && load_release_i && nonsync_en_i && st_d.mod != bemc_pkg::BEMC_MOD_OFF)
        |=> (st_q.nsc == 3'h6) && !gate_o.ls_on;
    endproperty
    a_nonsync: assert property (p_nonsync) else $error("non-sync window not six");

    property p_delay;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (st_q.st == bemc_pkg::BEMC_ST_SHUT) ##1 (st_q.st == bemc_pkg::BEMC_ST_DELAY)
        |-> !ramp_active_o [*2];
    endproperty
    a_delay: assert property (p_delay) else $error("ramp started without delay");

    // Pulldown lets go once init is over and no fault is registered
    property p_release;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (clk_en_i && st_q.st != bemc_pkg::BEMC_ST_INIT && !st_q.fault) |=> !enable_pin_oe_o;
    endproperty
    a_release: assert property (p_release) else $error("pulldown not released");

    // Low synchronised enable stops the stage on the next edge
    property p_shut_low;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (clk_en_i && st_q.st != bemc_pkg::BEMC_ST_INIT && !en_sync)
        |=> (!converter_on_o && gate_o == '0);
    endproperty
    a_shut_low: assert property (p_shut_low) else $error("low enable left stage on");

    // Ramp follows the load band even with the forced bit set
    property p_ramp_mod;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (clk_en_i && st_d.st == bemc_pkg::BEMC_ST_RAMP
         && load_band_i == bemc_pkg::BEMC_LOAD_VLOW)
        |=> (modulation_o == bemc_pkg::BEMC_MOD_SKIP);
    endproperty
    a_ramp_mod: assert property (p_ramp_mod) else $error("ramp blocked pulse skip");

    // Skip pulses may only start at a switching clock boundary
    property p_skip_align;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (modulation_o == bemc_pkg::BEMC_MOD_SKIP && $rose(gate_o.hs_on)) |-> (st_q.div == '0);
    endproperty
    a_skip_align: assert property (p_skip_align) else $error("skip pulse off boundary");

endmodule // bemc_ctrl

`default_nettype wire

// [bemc_stack_model.sv]
// Stacked peer converters and system enable controller on the shared enable line
`timescale 1ns/1ps
`default_nettype none

module bemc_stack_model (
    input  wire logic dut_oe_i,     // Pulldown of the block active
    input  wire logic dut_val_i,    // Drive value of the block
    input  wire logic peer_hold_i,  // A peer is initializing or faulted
    input  wire logic host_en_i,    // System controller asks for run
    output var  logic line_o        // Resolved enable line level
);
    // Pull-up wins only while no party pulls the line low
    always_comb begin
        line_o = 1'b1;
        if (dut_oe_i) begin
            line_o = dut_val_i;
        end
        if (peer_hold_i) begin  // Peer holds line low in its own init or fault
            line_o = 1'b0;
        end
        if (!host_en_i) begin
            line_o = 1'b0;
        end
    end
endmodule // bemc_stack_model

`default_nettype wire

// [bemc_tb.sv]
// Self-checking testbench of the enable and mode control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end

module testbench;
    localparam int unsigned DLY = 4;         // Start delay cycles
    logic clk = 1'b0, rst_n = 1'b0, fault = 1'b0, alone = 1'b0, forced_pulse_width_operation = 1'b1;
    logic nsync = 1'b1, rel = 1'b0, peer = 1'b0, host = 1'b0, pin, oe, val;
    logic ready, on, ramp, fo, pso, seen;
    logic cen = 1'b1, skip = 1'b1;                          // Clock enable, skip request
    bemc_pkg::bemc_load_t  band = bemc_pkg::BEMC_LOAD_MID; // Load band
    bemc_pkg::bemc_mod_t   md;                              // Modulation seen
    bemc_pkg::bemc_gate_t  gate;                            // Gate drive seen
    bemc_pkg::bemc_strap_t strap;                           // Captured straps
    int errors = 0, cmp_count = 0, n;
    logic [3:0] rows [5] = '{4'b0010, 4'b1011, 4'b1100, 4'b0100, 4'b1001};

    // ------------------------------------------------------------------
    // Clock, design and shared line
    // ------------------------------------------------------------------
    always #5 clk = ~clk;
    bemc_stack_model stack (.dut_oe_i(oe), .dut_val_i(val), .peer_hold_i(peer),
        .host_en_i(host), .line_o(pin));
    bemc_ctrl #(.INIT_CYC(4), .DELAY_CYC(DLY), .RAMP_CYC(8), .DIV_CYC(8)) dut (
        .ref_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(cen), .enable_pin_i(pin),
        .enable_pin_o(val), .enable_pin_oe_o(oe), .fault_i(fault),
        .standalone_i(alone), .forced_pwm_select_i(forced_pulse_width_operation), .nonsync_en_i(nsync),
        .load_release_i(rel), .load_band_i(band), .skip_req_i(skip),
        .first_voltage_strap_i(1'b1), .second_voltage_strap_i(1'b0),
        .strap_o(strap), .serial_ready_o(ready), .converter_on_o(on),
        .ramp_active_o(ramp), .modulation_o(md), .gate_o(gate),
        .forced_pulse_width_operation_o(fo), .power_save_operation_o(pso));

    // Advance k edges, then drive just after the edge
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // Wait for the converter to come up, counting cycles
    task automatic wait_on();
        n = 0;
        while (on !== 1'b1 && n < 100) begin
            step(1);
            n++;
        end
        `CHK(on, 1'b1)
    endtask

    // Print counts and verdict, end the run
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        step(20);
        `CHK(oe, 1'b1)
        `CHK(ready, 1'b0)
        `CHK(gate, 2'h0)
        alone = 1'b1;
        rst_n = 1'b1;
        step(2);
        `CHK(oe, 1'b1)
        step(6);
        `CHK(ready, 1'b1)
        `CHK(oe, 1'b0)
        `CHK(strap, 2'h2)
        // Rows: fault, standalone, forced bit, expected pulldown
        foreach (rows[i]) begin
            {fault, alone, forced_pulse_width_operation} = rows[i][3:1];
            step(3);
            `CHK(oe, rows[i][0])
            `CHK(fo, forced_pulse_width_operation)
            `CHK(pso, !forced_pulse_width_operation)
        end
        {fault, alone, forced_pulse_width_operation} = 3'b001;  // Stacked use keeps both bits safe
        band = bemc_pkg::BEMC_LOAD_VLOW;
        step(3);
        host = 1'b1;
        wait_on();
        `CHK(n >= DLY && n <= DLY + 8, 1'b1)
        step(2);
        `CHK(ramp, 1'b1)
        `CHK(md, bemc_pkg::BEMC_MOD_SKIP)
        step(12);
        `CHK(md, bemc_pkg::BEMC_MOD_CCM)
        forced_pulse_width_operation = 1'b0;
        for (int b = 0; b < 4; b++) begin
            band = bemc_pkg::bemc_load_t'(b);
            step(20);
            `CHK(md, b == 0 ? bemc_pkg::BEMC_MOD_SKIP : b == 1 ?
                bemc_pkg::BEMC_MOD_DCM : bemc_pkg::BEMC_MOD_CCM)
        end
        // Skip mode: no request, no pulse; a request pulses within a period
        band = bemc_pkg::BEMC_LOAD_VLOW;
        skip = 1'b0;
        step(10);
        seen = 1'b0;
        repeat (16) begin step(1); seen |= gate.hs_on; end
        `CHK(seen, 1'b0)
        skip = 1'b1;
        repeat (9) begin step(1); seen |= gate.hs_on; end
        `CHK(seen, 1'b1)
        forced_pulse_width_operation = 1'b1;
        step(20);
        n = 0;
        while (gate.hs_on !== 1'b0 && n < 20) begin step(1); n++; end
        while (gate.hs_on !== 1'b1 && n < 40) begin step(1); n++; end
        n = 0;
        step(1);
        while (gate.hs_on !== 1'b0 && n < 20) begin step(1); n++; end
        while (gate.hs_on !== 1'b1 && n < 40) begin step(1); n++; end
        `CHK(n, 7)
        rel = 1'b1;
        step(1);
        rel = 1'b0;
        seen = 1'b0;
        repeat (40) begin step(1); seen |= gate.ls_on; end
        `CHK(seen, 1'b0)
        repeat (40) begin step(1); seen |= gate.ls_on; end
        `CHK(seen, 1'b1)
        // Option off: a load release leaves the low side switching
        nsync = 1'b0;
        rel = 1'b1;
        step(1);
        rel = 1'b0;
        seen = 1'b0;
        repeat (16) begin step(1); seen |= gate.ls_on; end
        `CHK(seen, 1'b1)
        peer = 1'b1;
        step(8);
        `CHK(on, 1'b0)
        `CHK(gate, 2'h0)
        `CHK(md, bemc_pkg::BEMC_MOD_OFF)
        peer = 1'b0;
        wait_on();
        fault = 1'b1;
        step(3);
        `CHK(oe, 1'b1)
        step(6);
        `CHK(on, 1'b0)
        `CHK(ready, 1'b1)
        `CHK(val, 1'b0)
        // Clock enable low freezes the held pulldown
        cen = 1'b0;
        fault = 1'b0;
        step(4);
        `CHK(oe, 1'b1)
        cen = 1'b1;
        step(3);
        `CHK(oe, 1'b0)
        final_report();
    end

    // Watchdog cuts a hang short
    initial begin
        #100us;
        errors++;
        final_report();
    end
endmodule // testbench

`default_nettype wire
